/* File: rtl/gain_regs_pkg.sv */
// Constants, register offsets and code helpers for the preamp gain registers.
package gain_regs_pkg;

    localparam int NUM_CH = 3;
    localparam int NUM_PIN = 7;

    // Register offsets, 16-bit registers at even addresses; index 0 is ch2.
    localparam logic [2:0][15:0] PAT_HI_OFS = {16'h2078, 16'h2070, 16'h2068};
    localparam logic [2:0][15:0] PAT_LO_OFS = {16'h207a, 16'h2072, 16'h206a};
    localparam logic [2:0][15:0] ANA_OFS = {16'h207c, 16'h2074, 16'h206c};
    localparam logic [2:0][15:0] DIG_OFS = {16'h207e, 16'h2076, 16'h206e};
    localparam logic [1:0][15:0] AUX_HI_OFS = {16'h20a4, 16'h20a0};
    localparam logic [1:0][15:0] AUX_LO_OFS = {16'h20a6, 16'h20a2};
    localparam logic [15:0] CLIP_OFS = 16'h3d1c;

    localparam logic [15:0] REG_RESET = 16'h0000;

    // Field positions.
    localparam int APPLY_BIT = 15;
    localparam int DRIVE_BIT = 15;
    localparam int ANA_W = 11;
    localparam int DIG_W = 8;
    localparam logic [15:0] CLIP_WR_MASK = 16'h80ef;

    // Pin vector order: dout2, dout3, dout4, chip select, cfg2, cfg3, cfg4.
    localparam int PIN_DOUT2 = 0;
    localparam int PIN_CFG2 = 4;

    // Code limits.
    localparam logic [10:0] ANA_POS_MAX = 11'h23f;
    localparam logic [10:0] ANA_NEG_MIN = 11'h5c0;
    localparam logic [7:0] DIG_POS_MAX = 8'h5f;
    localparam logic [7:0] DIG_NEG_MIN = 8'ha0;
    localparam logic [5:0] PAT_LEN_MAX = 6'h20;

    // Reserved analog codes are pulled to the nearest legal end.
    function automatic logic [10:0] clamp_ana(input logic [10:0] c);
        if (c > ANA_POS_MAX && c < ANA_NEG_MIN) begin
            return c[10] ? ANA_NEG_MIN : ANA_POS_MAX;
        end
        return c;
    endfunction

    // Reserved digital codes are pulled to the nearest legal end.
    function automatic logic [7:0] clamp_dig(input logic [7:0] c);
        if (c > DIG_POS_MAX && c < DIG_NEG_MIN) begin
            return c[7] ? DIG_NEG_MIN : DIG_POS_MAX;
        end
        return c;
    endfunction

endpackage

/* File: rtl/gain_chan_if.sv */
// Per-channel link between the register bank, scheduler and serializer.
`timescale 1ns/1ps
`default_nettype none
interface gain_chan_if;
    logic strobe;
    logic sched_tick;
    logic zero_cross;
    logic apply;
    logic bit_tick;
    logic [31:0] pattern;
    logic [5:0] len;
    logic sdo;
    logic busy;
    modport sched (input strobe, input sched_tick, input zero_cross,
                   output apply);
    modport ser (input apply, input bit_tick, input pattern, input len,
                 output sdo, output busy);
    modport bank (output strobe, output sched_tick, output zero_cross,
                  input apply, output bit_tick, output pattern, output len,
                  input sdo, input busy);
endinterface
`default_nettype wire

/* File: rtl/zero_cross_sched.sv */
// Holds a gain update request until a zero-crossing scheduling slot.
`timescale 1ns/1ps
`default_nettype none
module zero_cross_sched (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    gain_chan_if.sched lk
);
    typedef struct packed {
        logic pend;
        logic apply;
    } sched_t;

    sched_t s_q;
    sched_t s_d;
    logic fire;

    always_comb begin
        s_d = s_q;
        fire = s_q.pend & lk.sched_tick & lk.zero_cross;
        // A new request in the firing cycle stays pending for the next slot.
        s_d.pend = lk.strobe | (s_q.pend & ~fire);
        s_d.apply = fire;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign lk.apply = s_q.apply;
endmodule
`default_nettype wire

/* File: rtl/pattern_serializer.sv */
// Shifts the leading bits of a gain pattern out, first bit from the MSB.
`timescale 1ns/1ps
`default_nettype none
module pattern_serializer (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    gain_chan_if.ser lk
);
    typedef struct packed {
        logic [31:0] sh;
        logic [5:0] cnt;
        logic busy;
        logic sdo;
    } ser_t;

    ser_t s_q;
    ser_t s_d;
    logic [5:0] len_c;

    always_comb begin
        s_d = s_q;
        len_c = (lk.len > gain_regs_pkg::PAT_LEN_MAX) ?
                gain_regs_pkg::PAT_LEN_MAX : lk.len;
        if (lk.apply) begin
            s_d.sh = lk.pattern;
            s_d.cnt = len_c;
            s_d.busy = (len_c != 6'h00);
        end else if (lk.bit_tick && s_q.busy) begin
            s_d.sdo = s_q.sh[31];
            s_d.sh = {s_q.sh[30:0], 1'b0};
            s_d.cnt = s_q.cnt - 6'h01;
            // Trailing bits beyond the length are never sent.
            s_d.busy = (s_q.cnt != 6'h01);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign lk.sdo = s_q.sdo;
    assign lk.busy = s_q.busy;
endmodule
`default_nettype wire

/* File: rtl/preamp_gain_regs.sv */
// Preamp gain pattern, gain code and clip pin routing register bank.
//
// How it works
// - Upper pattern register holds bits 17-32, used only beyond 16 bits.
// - Lower pattern register holds bits 1-16 of the serial gain word.
// - Only the configured number of leading bits is shifted out.
// - Analog code 11 bits, 0.125 dB steps, positive up to 0x23F.
// - Negative analog codes 0x5C0 to 0x7FF; 0x240-0x5BF reserved.
// - Digital code 8 bits, 0.125 dB steps, positive up to 0x5F.
// - Negative digital codes 0xA0 to 0xFF; 0x60-0x9F reserved.
// - Writing 1 to digital code register bit 15 applies the channel's codes and pattern.
// - Updates wait for the next slot, zero-cross aligned.
// - Two auxiliary patterns with upper and lower registers alike.
// - Clip pad bit 15 picks push-pull (0) or open-drain (1) drive.
// - Bits 7, 6, 5 route clip onto configuration pins four to two.
// - Bit 3 routes clip onto the chip-select pin.
// - Bits 2, 1 and 0 route clip onto serial data outputs four to two.
// - All registers reset to zero except pin_oe_n, which resets to all ones: 0 dB gains, default pin roles.
`timescale 1ns/1ps
`default_nettype none
module preamp_gain_regs (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic [2:0][5:0] pattern_len,
    input wire logic sched_tick,
    input wire logic [2:0] zero_cross,
    input wire logic bit_tick,
    output logic [2:0] gain_sdo,
    output logic [2:0] gain_busy,
    output logic [2:0] gain_applied,
    output logic [10:0] ch2_analog_gain_code,
    output logic [10:0] ch3_analog_gain_code,
    output logic [10:0] ch4_analog_gain_code,
    output logic [7:0] ch2_digital_gain_code,
    output logic [7:0] ch3_digital_gain_code,
    output logic [7:0] ch4_digital_gain_code,
    output logic [31:0] aux1_pattern,
    output logic [31:0] aux2_pattern,
    input wire logic [3:0] clip_in,
    input wire logic [6:0] func_out,
    input wire logic [6:0] func_oe_n,
    output logic [6:0] pin_out,
    output logic [6:0] pin_oe_n
);
    typedef struct packed {
        logic [2:0][15:0] pat_hi;
        logic [2:0][15:0] pat_lo;
        logic [2:0][10:0] ana;
        logic [2:0][10:0] ana_act;
        logic [2:0][7:0] dig;
        logic [2:0][7:0] dig_act;
        logic [1:0][15:0] aux_hi;
        logic [1:0][15:0] aux_lo;
        logic [15:0] clip;
        logic [15:0] rdata;
        logic [2:0] strobe;
        logic [6:0] pin_out;
        logic [6:0] pin_oe_n;
    } bank_t;

    bank_t regs_q;
    bank_t regs_d;
    logic [2:0] apply;
    logic [6:0] route;
    logic clip_any;
    logic open_drain;

    genvar g;
    generate
        for (g = 0; g < gain_regs_pkg::NUM_CH; g++) begin : g_ch
            gain_chan_if lk();

            assign lk.strobe = regs_q.strobe[g];
            assign lk.sched_tick = sched_tick;
            assign lk.zero_cross = zero_cross[g];
            assign lk.bit_tick = bit_tick;
            // Bits 1-16 lead, bits 17-32 follow.
            assign lk.pattern =
                {regs_q.pat_lo[g], regs_q.pat_hi[g]};
            assign lk.len = pattern_len[g];
            assign apply[g] = lk.apply;
            assign gain_sdo[g] = lk.sdo;
            assign gain_busy[g] = lk.busy;

            zero_cross_sched u_sched (
                .mclk(mclk),
                .reset(reset),
                .ce(ce),
                .lk(lk.sched)
            );

            pattern_serializer u_ser (
                .mclk(mclk),
                .reset(reset),
                .ce(ce),
                .lk(lk.ser)
            );
        end
    endgenerate

    // Pin vector bits map onto the clip pad register's route bits.
    assign route = {regs_q.clip[7:5], regs_q.clip[3:0]};
    assign clip_any = |clip_in;
    assign open_drain = regs_q.clip[gain_regs_pkg::DRIVE_BIT];

    always_comb begin
        regs_d = regs_q;
        regs_d.strobe = 3'h0;
        if (reg_wr) begin
            for (int i = 0; i < gain_regs_pkg::NUM_CH; i++) begin
                if (reg_addr == gain_regs_pkg::PAT_HI_OFS[i]) begin
                    regs_d.pat_hi[i] = reg_wdata;
                end
                if (reg_addr == gain_regs_pkg::PAT_LO_OFS[i]) begin
                    regs_d.pat_lo[i] = reg_wdata;
                end
                if (reg_addr == gain_regs_pkg::ANA_OFS[i]) begin
                    regs_d.ana[i] = reg_wdata[10:0];
                end
                if (reg_addr == gain_regs_pkg::DIG_OFS[i]) begin
                    regs_d.dig[i] = reg_wdata[7:0];
                    // Only a written 1 requests an update.
                    regs_d.strobe[i] =
                        reg_wdata[gain_regs_pkg::APPLY_BIT];
                end
            end
            for (int a = 0; a < 2; a++) begin
                if (reg_addr == gain_regs_pkg::AUX_HI_OFS[a]) begin
                    regs_d.aux_hi[a] = reg_wdata;
                end
                if (reg_addr == gain_regs_pkg::AUX_LO_OFS[a]) begin
                    regs_d.aux_lo[a] = reg_wdata;
                end
            end
            if (reg_addr == gain_regs_pkg::CLIP_OFS) begin
                regs_d.clip = reg_wdata & gain_regs_pkg::CLIP_WR_MASK;
            end
        end

        if (reg_rd) begin
            regs_d.rdata = gain_regs_pkg::REG_RESET;
            for (int i = 0; i < gain_regs_pkg::NUM_CH; i++) begin
                if (reg_addr == gain_regs_pkg::PAT_HI_OFS[i]) begin
                    regs_d.rdata = regs_q.pat_hi[i];
                end
                if (reg_addr == gain_regs_pkg::PAT_LO_OFS[i]) begin
                    regs_d.rdata = regs_q.pat_lo[i];
                end
                if (reg_addr == gain_regs_pkg::ANA_OFS[i]) begin
                    regs_d.rdata = {5'h00, regs_q.ana[i]};
                end
                if (reg_addr == gain_regs_pkg::DIG_OFS[i]) begin
                    // The apply bit always reads back as zero.
                    regs_d.rdata = {8'h00, regs_q.dig[i]};
                end
            end
            for (int a = 0; a < 2; a++) begin
                if (reg_addr == gain_regs_pkg::AUX_HI_OFS[a]) begin
                    regs_d.rdata = regs_q.aux_hi[a];
                end
                if (reg_addr == gain_regs_pkg::AUX_LO_OFS[a]) begin
                    regs_d.rdata = regs_q.aux_lo[a];
                end
            end
            if (reg_addr == gain_regs_pkg::CLIP_OFS) begin
                regs_d.rdata = regs_q.clip;
            end
        end

        // Codes and pattern take effect together at the scheduled slot.
        for (int i = 0; i < gain_regs_pkg::NUM_CH; i++) begin
            if (apply[i]) begin
                regs_d.ana_act[i] =
                    gain_regs_pkg::clamp_ana(regs_q.ana[i]);
                regs_d.dig_act[i] =
                    gain_regs_pkg::clamp_dig(regs_q.dig[i]);
            end
        end

        for (int p = 0; p < gain_regs_pkg::NUM_PIN; p++) begin
            if (route[p]) begin
                if (open_drain) begin
                    // Open drain pulls low on clip and releases otherwise.
                    regs_d.pin_out[p] = 1'b0;
                    regs_d.pin_oe_n[p] = ~clip_any;
                end else begin
                    regs_d.pin_out[p] = clip_any;
                    regs_d.pin_oe_n[p] = 1'b0;
                end
            end else begin
                regs_d.pin_out[p] = func_out[p];
                regs_d.pin_oe_n[p] = func_oe_n[p];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            regs_q <= '0;
            regs_q.pin_oe_n <= 7'h7f;
        end else if (ce) begin
            regs_q <= regs_d;
        end
    end

    assign reg_rdata = regs_q.rdata;
    assign gain_applied = apply;
    assign ch2_analog_gain_code = regs_q.ana_act[0];
    assign ch3_analog_gain_code = regs_q.ana_act[1];
    assign ch4_analog_gain_code = regs_q.ana_act[2];
    assign ch2_digital_gain_code = regs_q.dig_act[0];
    assign ch3_digital_gain_code = regs_q.dig_act[1];
    assign ch4_digital_gain_code = regs_q.dig_act[2];
    assign aux1_pattern = {regs_q.aux_lo[0], regs_q.aux_hi[0]};
    assign aux2_pattern = {regs_q.aux_lo[1], regs_q.aux_hi[1]};
    assign pin_out = regs_q.pin_out;
    assign pin_oe_n = regs_q.pin_oe_n;
endmodule
`default_nettype wire

/* File: test/preamp_gain_regs_properties.sv */
// Concurrent checks on the gain register bank top-level ports.
`timescale 1ns/1ps
`default_nettype none
module preamp_gain_regs_properties (
    input wire logic mclk,
    input wire logic reset,
    input wire logic reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_rdata,
    input wire logic [2:0][5:0] pattern_len,
    input wire logic sched_tick,
    input wire logic [2:0] zero_cross,
    input wire logic [2:0] gain_busy,
    input wire logic [2:0] gain_applied,
    input wire logic [10:0] ch2_analog_gain_code,
    input wire logic [10:0] ch4_analog_gain_code,
    input wire logic [7:0] ch3_digital_gain_code,
    input wire logic [7:0] ch4_digital_gain_code,
    input wire logic [6:0] pin_oe_n
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    reset_release_a: assert property (
        $fell(reset) |-> gain_applied == 3'h0 && pin_oe_n == 7'h7f)
        else $error("outputs not at reset state after release");
    apply_cause_a: assert property (
        gain_applied[1] |-> $past(sched_tick && zero_cross[1]))
        else $error("apply without a zero-cross slot");
    ch2_ana_hold_a: assert property (
        $changed(ch2_analog_gain_code) |-> $past(gain_applied[0]))
        else $error("analog code moved outside an apply");
    ch3_dig_hold_a: assert property (
        $changed(ch3_digital_gain_code) |-> $past(gain_applied[1]))
        else $error("digital code moved outside an apply");
    ana_legal_a: assert property (
        !(ch4_analog_gain_code inside {[11'h240:11'h5bf]}))
        else $error("reserved analog code applied");
    dig_legal_a: assert property (
        !(ch4_digital_gain_code inside {[8'h60:8'h9f]}))
        else $error("reserved digital code applied");
    strobe_reads_zero_a: assert property (
        reg_rd && reg_addr == 16'h2076 |=> reg_rdata[15:8] == 8'h00)
        else $error("apply or reserved bits read back nonzero");
    busy_start_a: assert property (
        gain_applied[2] && pattern_len[2] != 6'h00 |=> gain_busy[2])
        else $error("serializer did not start after apply");
endmodule
`default_nettype wire

/* File: test/preamp_gain_port_model.sv */
// Behavioural external preamp gain port that clocks in the serial pattern.
`timescale 1ns/1ps
`default_nettype none
module preamp_gain_port_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [2:0] gain_sdo,
    input wire logic [2:0] gain_busy,
    input wire logic [2:0] gain_applied,
    output logic bit_tick,
    output logic [2:0][31:0] cap,
    output logic [2:0][5:0] cnt
);
    logic [1:0] div = 2'h0;
    logic t1 = 1'b0;
    logic t2 = 1'b0;
    logic [2:0] b1 = 3'h0;
    logic [2:0] b2 = 3'h0;
    // Ticks only while a frame is in progress; bits sampled two edges late.
    always @(posedge mclk) begin
        div <= reset ? 2'h0 : div + 2'h1;
        bit_tick <= !reset && (|gain_busy) && div == 2'h3;
        t1 <= bit_tick;
        t2 <= t1;
        b1 <= gain_busy;
        b2 <= b1;
        for (int i = 0; i < 3; i++) begin
            if (reset || gain_applied[i]) begin
                cap[i] <= 32'h0;
                cnt[i] <= 6'h0;
            end else if (t2 && b2[i]) begin
                cap[i] <= {cap[i][30:0], gain_sdo[i]};
                cnt[i] <= cnt[i] + 6'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: test/test_preamp_gain_regs.sv */
// Self-checking bench for the preamp gain register bank.
`timescale 1ns/1ps
`default_nettype none
module test_preamp_gain_regs;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_addr = 16'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic [15:0] reg_rdata;
    logic [2:0][5:0] pattern_len = '0;
    logic sched_tick = 1'b0;
    logic [2:0] zero_cross = 3'h0;
    logic bit_tick;
    logic [2:0] gain_sdo;
    logic [2:0] gain_busy;
    logic [2:0] gain_applied;
    logic [2:0][10:0] ana;
    logic [2:0][7:0] dig;
    logic [31:0] aux1;
    logic [31:0] aux2;
    logic [3:0] clip_in = 4'h0;
    logic [6:0] func_out = 7'h55;
    logic [6:0] func_oe_n = 7'h2a;
    logic [6:0] pin_out;
    logic [6:0] pin_oe_n;
    logic [2:0][31:0] cap;
    logic [2:0][5:0] cnt;
    int err_total = 0;
    int n_compared = 0;
    int cycles = 0;
    always #12.5 mclk = ~mclk;
    preamp_gain_regs u_dut (.mclk(mclk), .reset(reset), .ce(ce),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .pattern_len(pattern_len), .sched_tick(sched_tick),
        .zero_cross(zero_cross), .bit_tick(bit_tick), .gain_sdo(gain_sdo),
        .gain_busy(gain_busy), .gain_applied(gain_applied),
        .ch2_analog_gain_code(ana[0]), .ch3_analog_gain_code(ana[1]),
        .ch4_analog_gain_code(ana[2]), .ch2_digital_gain_code(dig[0]),
        .ch3_digital_gain_code(dig[1]), .ch4_digital_gain_code(dig[2]),
        .aux1_pattern(aux1), .aux2_pattern(aux2), .clip_in(clip_in),
        .func_out(func_out), .func_oe_n(func_oe_n), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n));
    preamp_gain_port_model u_amp (.mclk(mclk), .reset(reset),
        .gain_sdo(gain_sdo), .gain_busy(gain_busy),
        .gain_applied(gain_applied), .bit_tick(bit_tick), .cap(cap),
        .cnt(cnt));
    task automatic close_out();
        if (err_total == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rchk(input logic [15:0] a, input logic [15:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk({16'h0, reg_rdata}, {16'h0, e});
    endtask
    // Offers a one-cycle slot to the channels in m.
    // It returns while the apply pulse that the slot causes still stands.
    task automatic slot(input logic [2:0] m);
        @(posedge mclk);
        sched_tick <= 1'b1;
        zero_cross <= m;
        @(posedge mclk);
        sched_tick <= 1'b0;
        zero_cross <= 3'h0;
        #1;
    endtask
    task automatic t_reset();
        for (int i = 0; i < 3; i++) begin
            rchk(gain_regs_pkg::PAT_HI_OFS[i], 16'h0);
            rchk(gain_regs_pkg::PAT_LO_OFS[i], 16'h0);
            rchk(gain_regs_pkg::ANA_OFS[i], 16'h0);
            rchk(gain_regs_pkg::DIG_OFS[i], 16'h0);
            chk({13'h0, ana[i], dig[i]}, 32'h0);
        end
        rchk(gain_regs_pkg::CLIP_OFS, 16'h0);
        chk(aux1, 32'h0);
        chk(aux2, 32'h0);
    endtask
    task automatic t_regs();
        wr(gain_regs_pkg::DIG_OFS[0], 16'h7fff);
        rchk(gain_regs_pkg::DIG_OFS[0], 16'h00ff);
        wr(16'h2000, 16'hbeef);
        rchk(16'h2000, 16'h0);
        wr(gain_regs_pkg::AUX_HI_OFS[0], 16'h1234);
        wr(gain_regs_pkg::AUX_LO_OFS[0], 16'habcd);
        wr(gain_regs_pkg::AUX_HI_OFS[1], 16'h5678);
        wr(gain_regs_pkg::AUX_LO_OFS[1], 16'hef01);
        #1 chk(aux1, 32'habcd1234);
        chk(aux2, 32'hef015678);
        rchk(gain_regs_pkg::AUX_LO_OFS[1], 16'hef01);
        // A write while the clock enable is low must leave no trace.
        @(posedge mclk);
        ce <= 1'b0;
        wr(gain_regs_pkg::AUX_HI_OFS[0], 16'h0bad);
        ce <= 1'b1;
        rchk(gain_regs_pkg::AUX_HI_OFS[0], 16'h1234);
        slot(3'h7);
        chk({29'h0, gain_applied}, 32'h0);
        @(posedge mclk);
        #1 chk({13'h0, ana[0], dig[0]}, 32'h0);
    endtask
    task automatic t_apply(input int ch, input logic [5:0] len,
        input logic [15:0] hi, input logic [15:0] lo, input logic [10:0] a,
        input logic [7:0] d, input logic [10:0] ae, input logic [7:0] de);
        logic [31:0] w;
        w = {lo, hi} >> (32 - len);
        @(posedge mclk);
        pattern_len[ch] <= len;
        wr(gain_regs_pkg::PAT_HI_OFS[ch], hi);
        wr(gain_regs_pkg::PAT_LO_OFS[ch], lo);
        wr(gain_regs_pkg::ANA_OFS[ch], {5'h1f, a});
        wr(gain_regs_pkg::DIG_OFS[ch], {8'h80, d});
        rchk(gain_regs_pkg::ANA_OFS[ch], {5'h0, a});
        rchk(gain_regs_pkg::DIG_OFS[ch], {8'h0, d});
        slot(~(3'h1 << ch));
        chk({29'h0, gain_applied}, 32'h0);
        @(posedge mclk);
        #1 chk({13'h0, ana[ch], dig[ch]}, 32'h0);
        slot(3'h1 << ch);
        chk({29'h0, gain_applied}, 32'h1 << ch);
        @(posedge mclk);
        #1 chk({21'h0, ana[ch]}, {21'h0, ae});
        chk({24'h0, dig[ch]}, {24'h0, de});
        for (int k = 0; k < 400 && gain_busy[ch] !== 1'b0; k++) begin
            @(posedge mclk);
        end
        repeat (3) @(posedge mclk);
        #1 chk({26'h0, cnt[ch]}, {26'h0, len});
        chk(cap[ch], w);
    endtask
    task automatic pin(input logic [3:0] c, input logic [6:0] eo,
        input logic [6:0] eoe);
        @(posedge mclk);
        clip_in <= c;
        repeat (2) @(posedge mclk);
        #1 chk({25'h0, pin_out}, {25'h0, eo});
        chk({25'h0, pin_oe_n}, {25'h0, eoe});
    endtask
    task automatic t_clip();
        wr(gain_regs_pkg::CLIP_OFS, 16'hffff);
        rchk(gain_regs_pkg::CLIP_OFS, 16'h80ef);
        wr(gain_regs_pkg::CLIP_OFS, 16'h00ef);
        pin(4'h4, 7'h7f, 7'h00);
        pin(4'h0, 7'h00, 7'h00);
        wr(gain_regs_pkg::CLIP_OFS, 16'h80a2);
        pin(4'h8, 7'h05, 7'h28);
        pin(4'h0, 7'h05, 7'h7a);
        wr(gain_regs_pkg::CLIP_OFS, 16'h0000);
        pin(4'h1, 7'h55, 7'h2a);
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_regs();
        // Each analog code below is the host's match for its pattern.
        t_apply(0, 6'd12, 16'hffff, 16'hb3c7, 11'h300, 8'h70, 11'h23f, 8'h5f);
        t_apply(1, 6'd20, 16'h9abc, 16'h1234, 11'h5c0, 8'ha0, 11'h5c0, 8'ha0);
        t_apply(2, 6'd32, 16'h8001, 16'hc35a, 11'h23f, 8'hff, 11'h23f, 8'hff);
        t_clip();
        close_out();
    end
endmodule
bind preamp_gain_regs preamp_gain_regs_properties u_props (.mclk(mclk),
    .reset(reset), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .pattern_len(pattern_len),
    .sched_tick(sched_tick), .zero_cross(zero_cross),
    .gain_busy(gain_busy), .gain_applied(gain_applied),
    .ch2_analog_gain_code(ch2_analog_gain_code),
    .ch4_analog_gain_code(ch4_analog_gain_code),
    .ch3_digital_gain_code(ch3_digital_gain_code),
    .ch4_digital_gain_code(ch4_digital_gain_code), .pin_oe_n(pin_oe_n));
`default_nettype wire
